/* File: wafm_consts.svh */
// Offsets, field positions, reset values and timing counts of the mode registers
// ----------------------------------------------------------------------------
// Operation
// ----------------------------------------------------------------------------
`ifndef WAFM_CONSTS_SVH
`define WAFM_CONSTS_SVH

`define WAFM_OFS_SAMPLING_MODE  8'h0C
`define WAFM_OFS_TERM_MODE      8'h0D
`define WAFM_RST_SAMPLING_MODE  8'h00
`define WAFM_RST_TERM_MODE      8'h3F
`define WAFM_SRC_LSB            0
`define WAFM_RATE_LSB           3
`define WAFM_SWAP_BIT           5
`define WAFM_LINE_TERM_LSB      0
`define WAFM_TERM_LSB           3
`define WAFM_FORMULA_LSB        6
`define WAFM_CLK_PREDIV         3
`define WAFM_RATE_BASE_DIV      128
`define WAFM_NEG_FLAG_DEFAULT   3'h0

`endif

/* File: wafm_host_model.sv */
// Host model issuing strobed register cycles
`timescale 1ns/1ps
`default_nettype none
module wafm_host_model
(
	// Clock
	input  wire logic       sys_clk,
	// Register port
	output logic [7:0]      reg_addr,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic [7:0]      reg_wdata,
	input  wire logic [7:0] reg_rdata
);
	initial
	begin
		reg_addr = 8'hFF;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'hA5;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a == 8'h0C && v[2:1] == 2'h3)
			v[2] = 1'b0;
		@(posedge sys_clk);
		#1;
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(posedge sys_clk);
		#1;
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~v;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge sys_clk);
		#1;
		d = reg_rdata;
		reg_rd = 1'b0;
		reg_addr = ~a;
	endtask : rd
endmodule : wafm_host_model
`default_nettype wire

/* File: wafm_mode_config.sv */
// Waveform sampling mode and active energy term mode registers with their datapath effects
`timescale 1ns/1ps
`default_nettype none
`include "wafm_consts.svh"

module wafm_mode_config
(
	// Clock, reset, enable
	input  wire logic                   sys_clk,
	input  wire logic                   reset,
	input  wire logic                   ce,
	// Register port from the serial interface
	input  wire logic [7:0]             reg_addr,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	input  wire logic [7:0]             reg_wdata,
	output logic      [7:0]             reg_rdata,
	// Datapath inputs
	input  wire wafm_pkg::wafm_samples_s  samples,
	input  wire wafm_pkg::wafm_line_inc_s line_inc,
	// Waveform sample path
	output logic                        sample_strobe,
	output wafm_pkg::wafm_sample_t      waveform_sample,
	// Line accumulation routing
	output wafm_pkg::wafm_energy_t      line_active_acc_in,
	output wafm_pkg::wafm_energy_t      line_apparent_acc_in,
	// Active power and negative flags
	output wafm_pkg::wafm_power_t       active_power,
	output wafm_pkg::wafm_power_t       line_active_power,
	output logic      [2:0]             neg_flags
);

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	logic [7:0]              sampling_mode_r;
	logic [7:0]              term_mode_r;
	logic [2:0]              sample_source_select;
	logic [1:0]              sample_update_rate;
	logic                    line_accum_swap;
	logic [2:0]              line_term_enables;
	logic [2:0]              term_enables;
	wafm_pkg::wafm_formula_e formula_select;
	logic                    wr_sampling;

	assign wr_sampling          = reg_wr && (reg_addr == `WAFM_OFS_SAMPLING_MODE);
	assign sample_source_select = sampling_mode_r[`WAFM_SRC_LSB +: 3];
	assign sample_update_rate   = sampling_mode_r[`WAFM_RATE_LSB +: 2];
	assign line_accum_swap      = sampling_mode_r[`WAFM_SWAP_BIT];
	assign line_term_enables    = term_mode_r[`WAFM_LINE_TERM_LSB +: 3];
	assign term_enables         = term_mode_r[`WAFM_TERM_LSB +: 3];
	assign formula_select       = wafm_pkg::wafm_formula_e'(term_mode_r[`WAFM_FORMULA_LSB +: 2]);

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			sampling_mode_r <= `WAFM_RST_SAMPLING_MODE;
			term_mode_r     <= `WAFM_RST_TERM_MODE;
		end
		else if (ce && reg_wr)
		begin
			if (reg_addr == `WAFM_OFS_SAMPLING_MODE)
				sampling_mode_r <= reg_wdata;
			else if (reg_addr == `WAFM_OFS_TERM_MODE)
				term_mode_r <= reg_wdata;
		end
	end

	// Unmapped addresses read zero
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			reg_rdata <= 8'h00;
		else if (ce && reg_rd)
		begin
			if (reg_addr == `WAFM_OFS_SAMPLING_MODE)
				reg_rdata <= sampling_mode_r;
			else if (reg_addr == `WAFM_OFS_TERM_MODE)
				reg_rdata <= term_mode_r;
			else
				reg_rdata <= 8'h00;
		end
	end

	// ------------------------------------------------------------------------
	// Sample update rate
	// ------------------------------------------------------------------------
	logic [11:0] rate_cnt_r;
	logic [11:0] rate_period_m1;

	// clock divided by three, then by 128 to 1024
	assign rate_period_m1 = 12'((`WAFM_CLK_PREDIV * `WAFM_RATE_BASE_DIV) << sample_update_rate) - 12'h001;
	assign sample_strobe  = ce && (rate_cnt_r == 12'h000);

	// A sampling mode write restarts the divider so a new rate starts on a clean period
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			rate_cnt_r <= 12'h000;
		else if (ce)
		begin
			if (wr_sampling)
				rate_cnt_r <= 12'((`WAFM_CLK_PREDIV * `WAFM_RATE_BASE_DIV) << reg_wdata[`WAFM_RATE_LSB +: 2]) - 12'h001;
			else if (rate_cnt_r == 12'h000)
				rate_cnt_r <= rate_period_m1;
			else
				rate_cnt_r <= rate_cnt_r - 12'h001;
		end
	end

	// ------------------------------------------------------------------------
	// Waveform source
	// ------------------------------------------------------------------------
	// channel selected by source code
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			waveform_sample <= 12'sh000;
		else if (sample_strobe)
		begin
			case (sample_source_select)
				wafm_pkg::WAFM_SRC_VA: waveform_sample <= samples.va;
				wafm_pkg::WAFM_SRC_VB: waveform_sample <= samples.vb;
				wafm_pkg::WAFM_SRC_VC: waveform_sample <= samples.vc;
				wafm_pkg::WAFM_SRC_IA: waveform_sample <= samples.ia;
				wafm_pkg::WAFM_SRC_IB: waveform_sample <= samples.ib;
				wafm_pkg::WAFM_SRC_IC: waveform_sample <= samples.ic;
				// Reserved codes hold the last sample
				default:               waveform_sample <= waveform_sample;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Line accumulation routing
	// ------------------------------------------------------------------------
	// swap reactive into active, active into apparent
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			line_active_acc_in   <= 24'sh000000;
			line_apparent_acc_in <= 24'sh000000;
		end
		else if (ce)
		begin
			line_active_acc_in   <= line_accum_swap ? line_inc.reactive : line_inc.active;
			line_apparent_acc_in <= line_accum_swap ? line_inc.active : line_inc.apparent;
		end
	end

	// ------------------------------------------------------------------------
	// Active energy formula
	// ------------------------------------------------------------------------
	function automatic wafm_pkg::wafm_power_t term_sum(input wafm_pkg::wafm_term_t t1,
		input wafm_pkg::wafm_term_t t2, input wafm_pkg::wafm_term_t t3, input logic [2:0] en);
		term_sum = (en[2] ? 28'(t1) : 28'sh0000000)
			+ (en[1] ? 28'(t2) : 28'sh0000000)
			+ (en[0] ? 28'(t3) : 28'sh0000000);
	endfunction : term_sum

	logic signed [12:0]   ia_minus_ib;
	logic signed [12:0]   ic_minus_ib;
	wafm_pkg::wafm_term_t term1;
	wafm_pkg::wafm_term_t term2;
	wafm_pkg::wafm_term_t term3;
	wafm_pkg::wafm_term_t pa;
	wafm_pkg::wafm_term_t pb;
	wafm_pkg::wafm_term_t pc;
	wafm_pkg::wafm_term_t pa_two_w;
	wafm_pkg::wafm_term_t pc_two_w;

	// Operands widened first, else the product keeps only twelve bits
	assign ia_minus_ib = 13'(samples.ia) - 13'(samples.ib);
	assign ic_minus_ib = 13'(samples.ic) - 13'(samples.ib);
	assign pa          = 26'(samples.va) * 26'(samples.ia);
	assign pb          = 26'(samples.vb) * 26'(samples.ib);
	assign pc          = 26'(samples.vc) * 26'(samples.ic);
	assign pa_two_w    = 26'(samples.va) * 26'(ia_minus_ib);
	assign pc_two_w    = 26'(samples.vc) * 26'(ic_minus_ib);

	always_comb
	begin
		case (formula_select)
			wafm_pkg::WAFM_FORM_SUM:   {term1, term2, term3} = {pa, pb, pc};
			wafm_pkg::WAFM_FORM_TWO_W: {term1, term2, term3} = {pa_two_w, 26'sh0000000, pc_two_w};
			wafm_pkg::WAFM_FORM_MIXED: {term1, term2, term3} = {pa_two_w, 26'sh0000000, pc};
			// Reserved code contributes nothing
			default:                   {term1, term2, term3} = 78'h0;
		endcase
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			active_power      <= 28'sh0000000;
			line_active_power <= 28'sh0000000;
		end
		else if (ce)
		begin
			active_power      <= term_sum(term1, term2, term3, term_enables);
			line_active_power <= term_sum(term1, term2, term3, line_term_enables);
		end
	end

	// ------------------------------------------------------------------------
	// Negative power flags, bit 0 phase A .. bit 2 phase C
	// ------------------------------------------------------------------------
	logic [2:0] neg_sign;
	assign neg_sign = {pc[25], pb[25], pa[25]};

	for (genvar g = 0; g < 3; g++)
	begin : g_neg
		always_ff @(posedge sys_clk or posedge reset)
		begin
			if (reset)
				neg_flags[g] <= 1'((`WAFM_NEG_FLAG_DEFAULT) >> g);
			else if (ce)
				neg_flags[g] <= term_enables[2 - g] ? neg_sign[g] : 1'((`WAFM_NEG_FLAG_DEFAULT) >> g);
		end
	end

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	logic [11:0] gap_r;

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			gap_r <= 12'h000;
		else if (ce)
			gap_r <= (wr_sampling || sample_strobe) ? 12'h000 : gap_r + 12'h001;
	end

	property p_src_ia;
		@(posedge sys_clk) disable iff (reset)
		sample_strobe && sample_source_select == 3'h3 |=> waveform_sample == $past(samples.ia);
	endproperty
	a_src_ia: assert property (p_src_ia) else $error("waveform sample not current A");

	property p_rate_gap;
		@(posedge sys_clk) disable iff (reset)
		sample_strobe && !$past(reset) |-> gap_r == rate_period_m1;
	endproperty
	a_rate_gap: assert property (p_rate_gap) else $error("sample strobe spacing wrong");

	property p_swap;
		@(posedge sys_clk) disable iff (reset)
		ce && line_accum_swap |=> line_active_acc_in == $past(line_inc.reactive)
			&& line_apparent_acc_in == $past(line_inc.active);
	endproperty
	a_swap: assert property (p_swap) else $error("line swap routing wrong");

	property p_first_term;
		@(posedge sys_clk) disable iff (reset)
		ce && term_enables == 3'h4 && formula_select == wafm_pkg::WAFM_FORM_SUM
			|=> active_power == 28'($past(pa));
	endproperty
	a_first_term: assert property (p_first_term) else $error("first term gating wrong");

	property p_neg_off;
		@(posedge sys_clk) disable iff (reset)
		ce && !term_enables[1] |=> neg_flags[1] == 1'b0;
	endproperty
	a_neg_off: assert property (p_neg_off) else $error("disabled flag not default");

	property p_line_off;
		@(posedge sys_clk) disable iff (reset)
		ce && line_term_enables == 3'h0 |=> line_active_power == 28'sh0000000;
	endproperty
	a_line_off: assert property (p_line_off) else $error("line terms not gated");

	property p_two_w_mid;
		@(posedge sys_clk) disable iff (reset)
		ce && term_enables == 3'h2 && formula_select == wafm_pkg::WAFM_FORM_TWO_W
			|=> active_power == 28'sh0000000;
	endproperty
	a_two_w_mid: assert property (p_two_w_mid) else $error("two-wattmeter middle term not zero");

	property p_neg_a;
		@(posedge sys_clk) disable iff (reset)
		ce && term_enables[2] |=> neg_flags[0] == $past(pa[25]);
	endproperty
	a_neg_a: assert property (p_neg_a) else $error("phase A sign flag wrong");

	c_slow_rate: cover property (@(posedge sys_clk) disable iff (reset) sample_strobe && sample_update_rate == 2'h3);
	c_swap:      cover property (@(posedge sys_clk) disable iff (reset) ce && line_accum_swap);
	c_mixed:     cover property (@(posedge sys_clk) disable iff (reset) ce && formula_select == wafm_pkg::WAFM_FORM_MIXED);
	c_negative:  cover property (@(posedge sys_clk) disable iff (reset) neg_flags != 3'h0);

endmodule : wafm_mode_config

`default_nettype wire

/* File: wafm_pkg.sv */
// Types shared by the waveform and active energy mode configuration logic
`default_nettype none
package wafm_pkg;

	typedef logic signed [11:0] wafm_sample_t;
	typedef logic signed [23:0] wafm_energy_t;
	typedef logic signed [25:0] wafm_term_t;
	typedef logic signed [27:0] wafm_power_t;

	// Instantaneous channel samples, all on sys_clk
	typedef struct packed {
		wafm_sample_t va;
		wafm_sample_t vb;
		wafm_sample_t vc;
		wafm_sample_t ia;
		wafm_sample_t ib;
		wafm_sample_t ic;
	} wafm_samples_s;

	// Line-cycle energy increments from the accumulation path
	typedef struct packed {
		wafm_energy_t active;
		wafm_energy_t reactive;
		wafm_energy_t apparent;
	} wafm_line_inc_s;

	typedef enum logic [2:0] {
		WAFM_SRC_VA = 3'h0,
		WAFM_SRC_VB = 3'h1,
		WAFM_SRC_VC = 3'h2,
		WAFM_SRC_IA = 3'h3,
		WAFM_SRC_IB = 3'h4,
		WAFM_SRC_IC = 3'h5
	} wafm_src_e;

	typedef enum logic [1:0] {
		WAFM_FORM_SUM   = 2'h0,
		WAFM_FORM_TWO_W = 2'h1,
		WAFM_FORM_MIXED = 2'h2,
		WAFM_FORM_RSVD  = 2'h3
	} wafm_formula_e;

endpackage : wafm_pkg
`default_nettype wire

/* File: waveform_and_active_energy_mode_config_test.sv */
// Self-checking bench for the mode configuration block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
	$display("BAD t=%0t got %h exp %h", $time, g, e); end end
module waveform_and_active_energy_mode_config_test;
	logic                     sys_clk, reset, ce, reg_wr, reg_rd, sample_strobe;
	logic [7:0]               reg_addr, reg_wdata, reg_rdata, d;
	logic [2:0]               neg_flags, src;
	logic [1:0]               rate;
	wafm_pkg::wafm_samples_s  samples;
	wafm_pkg::wafm_line_inc_s line_inc;
	wafm_pkg::wafm_sample_t   waveform_sample;
	wafm_pkg::wafm_energy_t   line_active_acc_in, line_apparent_acc_in;
	wafm_pkg::wafm_power_t    active_power, line_active_power;
	int                       num_errors, comparisons, n, k;

	wafm_mode_config wafm_mode_config_i (.sys_clk, .reset, .ce, .reg_addr, .reg_wr, .reg_rd,
		.reg_wdata, .reg_rdata, .samples, .line_inc, .sample_strobe, .waveform_sample,
		.line_active_acc_in, .line_apparent_acc_in, .active_power, .line_active_power, .neg_flags);
	wafm_host_model wafm_host_model_i (.sys_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);

	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic results;
		if (num_errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results

	task automatic rnd;
		samples = 72'({$urandom(), $urandom(), $urandom()});
		line_inc = 72'({$urandom(), $urandom(), $urandom()});
	endtask : rnd

	task automatic step;
		@(posedge sys_clk);
		#1;
	endtask : step

	// Reference model of the term datapath
	task automatic check_dp(input logic [7:0] w);
		int va, vb, vc, ia, ib, ic, s1, s2;
		int t[$];
		va = samples.va;
		vb = samples.vb;
		vc = samples.vc;
		ia = samples.ia;
		ib = samples.ib;
		ic = samples.ic;
		case (w[7:6])
			2'h0: t = '{va * ia, vb * ib, vc * ic};
			2'h1: t = '{va * (ia - ib), 0, vc * (ic - ib)};
			2'h2: t = '{va * (ia - ib), 0, vc * ic};
			default: t = '{0, 0, 0};
		endcase
		s1 = (w[5] ? t[0] : 0) + (w[4] ? t[1] : 0) + (w[3] ? t[2] : 0);
		s2 = (w[2] ? t[0] : 0) + (w[1] ? t[1] : 0) + (w[0] ? t[2] : 0);
		`CHK(active_power, 28'(s1))
		`CHK(line_active_power, 28'(s2))
		`CHK(neg_flags, {w[3] && vc * ic < 0, w[4] && vb * ib < 0, w[5] && va * ia < 0})
	endtask : check_dp

	initial
	begin
		#160000;
		num_errors++;
		results();
	end

	initial
	begin
		reset = 1'b1;
		ce = 1'b1;
		samples = '0;
		line_inc = '0;
		void'($urandom(30291));
		repeat (12) @(posedge sys_clk);
		#1;
		reset = 1'b0;
		wafm_host_model_i.rd(8'h0C, d);
		`CHK(d, 8'h00)
		wafm_host_model_i.rd(8'h0D, d);
		`CHK(d, 8'h3F)
		wafm_host_model_i.rd(8'h0E, d);
		`CHK(d, 8'h00)
		// Every source, then every rate
		for (k = 0; k < 10; k++)
		begin
			src = 3'(k % 6);
			rate = (k < 6) ? 2'h0 : 2'(k - 6);
			rnd();
			wafm_host_model_i.wr(8'h0C, {3'h0, rate, src});
			n = 0;
			while (sample_strobe !== 1'b1 && n < 4000)
			begin
				step();
				n++;
			end
			step();
			`CHK(waveform_sample, 12'(samples >> (12 * (5 - src))))
			n = 1;
			while (sample_strobe !== 1'b1 && n < 4000)
			begin
				step();
				n++;
			end
			`CHK(n, 384 << rate)
		end
		// Line accumulation swap off and on
		for (k = 0; k < 2; k++)
		begin
			rnd();
			wafm_host_model_i.wr(8'h0C, 8'(k * 32));
			step();
			`CHK(line_active_acc_in, k ? line_inc.reactive : line_inc.active)
			`CHK(line_apparent_acc_in, k ? line_inc.active : line_inc.apparent)
		end
		// Every term mode value
		for (k = 0; k < 256; k++)
		begin
			rnd();
			wafm_host_model_i.wr(8'h0D, 8'(k));
			step();
			check_dp(8'(k));
			wafm_host_model_i.rd(8'h0D, d);
			`CHK(d, 8'(k))
		end
		// Disabled clock ignores writes
		ce = 1'b0;
		wafm_host_model_i.wr(8'h0D, 8'h00);
		ce = 1'b1;
		wafm_host_model_i.rd(8'h0D, d);
		`CHK(d, 8'hFF)
		results();
	end
endmodule : waveform_and_active_energy_mode_config_test
`default_nettype wire
